// file: rtl/ddr_phy_dll_impedance_ctrl.sv
// PHY loop, read latency and pad impedance control bank on AXI4-Lite
// Contract
// - Loop held in reset while control bit 5 is one
// - Loop powered down only with bit 4, self refresh and clock stop
// - Read capture delayed by 3-bit latency plus one memory clock cycles
// - Calibration starts only on rising edge of bit 15
// - Calibration function enabled by bit 13
// - P code bits 9-5 and N code bits 4-0 drive pads
// - Result register shows measured P and N codes, upper bits zero
// - Result access allowed only while gate bit 0 is one
`include "phy_ctrl_regs.svh"

module ddr_phy_dll_impedance_ctrl #(
  parameter int ADDR_W = 8,
  parameter int CAL_CYCLES_P = (`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic read_issue,
  output logic read_capture,
  input wire logic [4:0] measured_p_code,
  input wire logic [4:0] measured_n_code,
  output logic loop_reset,
  output logic loop_power_down,
  output logic impedance_calibration_enable,
  output logic calibration_busy,
  output logic [4:0] p_channel_code,
  output logic [4:0] n_channel_code
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W < 8) begin
    $error("ADDR_W must be at least 8");
  end
  if (CAL_CYCLES_P < 1 || CAL_CYCLES_P > 65535) begin
    $error("CAL_CYCLES_P out of range");
  end

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Word-aligned match of a bus address against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    logic [ADDR_W-1:0] ofs_w;
    ofs_w = ADDR_W'(ofs);
    hit = (addr[ADDR_W-1:2] == ofs_w[ADDR_W-1:2]);
  endfunction

  // Merge write data into a stored word honouring byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
    end
    merge = res;
  endfunction

  // ****************************************************************
  // Stored registers
  // ****************************************************************
  logic [15:0] loop_upper;
  logic [9:0] loop_mid;
  logic loop_reset_bit;
  logic loop_pwrdn_bit;
  logic [2:0] read_latency;
  logic cal_start_bit;
  logic cal_enable_bit;
  logic [4:0] p_code;
  logic [4:0] n_code;
  logic gate_en;
  logic self_refresh_request;
  logic memory_clock_stop_enable;
  logic [4:0] result_p;
  logic [4:0] result_n;
  phy_ctrl_pkg::cal_state_t cal_state;
  logic [15:0] cal_count;

  // ****************************************************************
  // Write channel: address and data accepted in either order
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;

  // Address decode for writes
  wire wr_loop = do_write && hit(wr_addr, `OFS_LOOP_LATENCY);
  wire wr_pad = do_write && hit(wr_addr, `OFS_PAD_IMPEDANCE);
  wire wr_result = do_write && hit(wr_addr, `OFS_CAL_RESULT);
  wire wr_gate = do_write && hit(wr_addr, `OFS_CAL_GATE);
  wire wr_refresh = do_write && hit(wr_addr, `OFS_REFRESH_CTRL);
  wire wr_known = wr_loop || wr_pad || wr_result || wr_gate || wr_refresh;
  // Gated result access answers SLVERR so software sees the block
  wire wr_ok = wr_loop || wr_pad || wr_gate || wr_refresh || (wr_result && gate_en);

  // Current register images, used for read-back and, all but the result word, for strobe merge
  wire [31:0] loop_word = {loop_upper, loop_mid, loop_reset_bit, loop_pwrdn_bit, 1'b1,
                           read_latency};
  wire [31:0] pad_word = {16'h0000, cal_start_bit, 1'b0, cal_enable_bit, 3'h0, p_code, n_code};
  wire [31:0] result_word = {22'h000000, result_p, result_n};
  wire [31:0] gate_word = {31'h00000000, gate_en};
  wire [31:0] refresh_word = {30'h00000000, memory_clock_stop_enable, self_refresh_request};

  wire [31:0] loop_next = merge(loop_word, wr_data, wr_strb);
  wire [31:0] pad_next = merge(pad_word, wr_data, wr_strb);
  wire [31:0] gate_next = merge(gate_word, wr_data, wr_strb);
  wire [31:0] refresh_next = merge(refresh_word, wr_data, wr_strb);

  // Handshake state: ready drops once an item is held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      aw_held <= have_aw && !do_write;
      w_held <= have_w && !do_write;
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !(have_aw && !do_write) && !do_write && !s_axi_bvalid && !aw_take;
      s_axi_wready <= !(have_w && !do_write) && !do_write && !s_axi_bvalid && !w_take;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : (wr_known ? 2'h2 : 2'h3);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control register updates
  // ****************************************************************
  // Loop control word; reserved fields 31-6 stored as written for read-back, reserved bit 3 always reads one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_upper <= `LOOP_UPPER_RST;
      loop_mid <= `LOOP_MID_RST;
      loop_reset_bit <= 1'b1;
      loop_pwrdn_bit <= 1'b0;
      read_latency <= `LAT_RST;
    end else if (wr_loop) begin
      loop_upper <= loop_next[31:16];
      loop_mid <= loop_next[15:6];
      loop_reset_bit <= loop_next[`BIT_LOOP_RESET];
      loop_pwrdn_bit <= loop_next[`BIT_LOOP_PWRDN];
      read_latency <= loop_next[`LAT_MSB:0];
    end
  end

  // Pad impedance control; reserved bits 14, 12-10 never stored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_start_bit <= 1'b0;
      cal_enable_bit <= 1'b0;
      p_code <= 5'h00;
      n_code <= `N_CODE_RST;
    end else if (wr_pad) begin
      cal_start_bit <= pad_next[`BIT_CAL_START];
      cal_enable_bit <= pad_next[`BIT_CAL_ENABLE];
      p_code <= pad_next[`P_MSB:`P_LSB];
      n_code <= pad_next[`N_MSB:`N_LSB];
    end
  end

  // Result gate and refresh-control copies of the power-down qualifiers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_en <= 1'b0;
      self_refresh_request <= 1'b0;
      memory_clock_stop_enable <= 1'b0;
    end else begin
      if (wr_gate) gate_en <= gate_next[`BIT_GATE_EN];
      if (wr_refresh) begin
        self_refresh_request <= refresh_next[`BIT_SELF_REFRESH];
        memory_clock_stop_enable <= refresh_next[`BIT_CLOCK_STOP];
      end
    end
  end

  // ****************************************************************
  // Calibration sequencer
  // ****************************************************************
  // Rising edge of the start bit, only when a write sets it from zero
  wire cal_trigger = wr_pad && !cal_start_bit && pad_next[`BIT_CAL_START];
  wire cal_go = cal_trigger && cal_enable_bit;

  // Fixed settle time stands in for the analog loop; result latched at the end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state <= phy_ctrl_pkg::CAL_IDLE;
      cal_count <= 16'h0000;
      result_p <= 5'h00;
      result_n <= 5'h00;
    end else begin
      case (cal_state)
        phy_ctrl_pkg::CAL_IDLE: begin
          if (cal_go) begin
            cal_state <= phy_ctrl_pkg::CAL_RUN;
            cal_count <= 16'(CAL_CYCLES_P - 1);
          end
        end
        phy_ctrl_pkg::CAL_RUN: begin
          if (!cal_enable_bit) begin
            cal_state <= phy_ctrl_pkg::CAL_IDLE;
          end else if (cal_count == 16'h0000) begin
            cal_state <= phy_ctrl_pkg::CAL_DONE;
            result_p <= measured_p_code;
            result_n <= measured_n_code;
          end else begin
            cal_count <= cal_count - 16'h0001;
          end
        end
        phy_ctrl_pkg::CAL_DONE: begin
          if (cal_go) begin
            cal_state <= phy_ctrl_pkg::CAL_RUN;
            cal_count <= 16'(CAL_CYCLES_P - 1);
          end
        end
        default: cal_state <= phy_ctrl_pkg::CAL_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_loop = hit(s_axi_araddr, `OFS_LOOP_LATENCY);
  wire rd_pad = hit(s_axi_araddr, `OFS_PAD_IMPEDANCE);
  wire rd_result = hit(s_axi_araddr, `OFS_CAL_RESULT);
  wire rd_gate = hit(s_axi_araddr, `OFS_CAL_GATE);
  wire rd_refresh = hit(s_axi_araddr, `OFS_REFRESH_CTRL);
  // Closed gate reads zero with SLVERR
  wire [31:0] rd_word = rd_loop ? loop_word :
                        rd_pad ? pad_word :
                        (rd_result && gate_en) ? result_word :
                        rd_gate ? gate_word :
                        rd_refresh ? refresh_word : 32'h00000000;
  wire [1:0] rd_resp = (rd_result && !gate_en) ? 2'h2 :
                       (rd_loop || rd_pad || rd_result || rd_gate || rd_refresh) ? 2'h0 : 2'h3;

  // One read outstanding; arready low while data waits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // PHY-facing outputs, all registered
  // ****************************************************************
  wire next_power_down = loop_pwrdn_bit && self_refresh_request && memory_clock_stop_enable;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_reset <= 1'b1;
      loop_power_down <= 1'b0;
      impedance_calibration_enable <= 1'b0;
      calibration_busy <= 1'b0;
      p_channel_code <= 5'h00;
      n_channel_code <= `N_CODE_RST;
    end else begin
      loop_reset <= loop_reset_bit;
      loop_power_down <= next_power_down;
      impedance_calibration_enable <= cal_enable_bit;
      calibration_busy <= (cal_state == phy_ctrl_pkg::CAL_RUN);
      p_channel_code <= p_code;
      n_channel_code <= n_code;
    end
  end

  // Read return capture aligned by the programmed latency
  read_capture_delay #(
    .MAX_LAT(8)
  ) u_capture (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .latency(read_latency),
    .read_issue(read_issue),
    .read_capture(read_capture)
  );

endmodule

// file: rtl/phy_ctrl_pkg.sv
// Types shared by the PHY control bank
package phy_ctrl_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_DONE
  } cal_state_t;
endpackage

// file: rtl/phy_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts for the PHY control bank
`ifndef PHY_CTRL_REGS_SVH
`define PHY_CTRL_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_LOOP_LATENCY 8'hE4
`define OFS_PAD_IMPEDANCE 8'hF0
`define OFS_CAL_RESULT 8'hF4
`define OFS_CAL_GATE 8'hF8
`define OFS_REFRESH_CTRL 8'hFC

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_LOOP_RESET 5
`define BIT_LOOP_PWRDN 4
`define BIT_LAT_RSVD_ONE 3
`define LAT_MSB 2
`define BIT_CAL_START 15
`define BIT_CAL_ENABLE 13
`define P_MSB 9
`define P_LSB 5
`define N_MSB 4
`define N_LSB 0
`define BIT_GATE_EN 0
`define BIT_SELF_REFRESH 0
`define BIT_CLOCK_STOP 1

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define LOOP_UPPER_RST 16'h5000
`define LOOP_MID_RST 10'h190
`define LAT_RST 3'h6
`define N_CODE_RST 5'h1F
`define CAL_TIME_NS 1000
`define CLK_PERIOD_NS 4

`endif

// file: rtl/read_capture_delay.sv
// Delay line that aligns the read capture strobe by a programmable latency
module read_capture_delay #(
  parameter int MAX_LAT = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] latency,
  input wire logic read_issue,
  output logic read_capture
);
  logic [MAX_LAT-1:0] pipe;
  logic [MAX_LAT-1:0] next_pipe;

  // Elaboration check: a 3-bit latency indexes exactly eight stages
  if (MAX_LAT != 8) begin
    $error("MAX_LAT must be 8 for a 3-bit latency");
  end

  // Shift in the issue strobe, one stage per memory clock
  assign next_pipe = {pipe[MAX_LAT-2:0], read_issue};

  // Stage holding issue delayed latency cycles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe <= '0;
      read_capture <= 1'b0;
    end else begin
      pipe <= next_pipe;
      read_capture <= next_pipe[latency];
    end
  end
endmodule

// file: tb/ddr_mem_model.sv
// Memory side model: read data returns after CAS latency plus board delay
module ddr_mem_model #(
  parameter int CAS_LAT = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] board_delay,
  input wire logic read_issue,
  output logic data_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pipe;

  // Each read command travels to the memory and back through the board
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe <= 8'h00;
    end else begin
      pipe <= {pipe[6:0], read_issue};
    end
  end

  // Board delay stays 2 to 4, so the matching latency is legal
  assign data_valid = pipe[CAS_LAT + board_delay - 1];
endmodule

// file: tb/ddr_phy_checker_assertions.sv
// Concurrent checks on the PHY control bank ports
`include "phy_ctrl_regs.svh"

module ddr_phy_checker #(
  parameter int ADDR_W = 8,
  parameter int CAL_CYCLES_P = 250
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic loop_reset,
  input wire logic loop_power_down,
  input wire logic impedance_calibration_enable,
  input wire logic calibration_busy,
  input wire logic [4:0] p_channel_code,
  input wire logic [4:0] n_channel_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] wa, ra;
  logic [31:0] wd, sh_loop, sh_pad;
  logic [1:0] sh_ref, quiet;
  logic gate_open, start;
  int bcnt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // A rising start bit counts only when the stored enable was already set
  assign start = wa == `OFS_PAD_IMPEDANCE && wd[15] && !sh_pad[15] && sh_pad[13];

  // Mirror of committed writes; the level checks on loop, pad and enable outputs run only once writes have settled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wa <= '0;
      ra <= '0;
      wd <= '0;
      sh_loop <= 32'h20;
      sh_pad <= 32'h1F;
      sh_ref <= 2'h0;
      gate_open <= 1'b0;
      quiet <= 2'h0;
      bcnt <= 0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
      quiet <= s_axi_bvalid ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      bcnt <= calibration_busy ? bcnt + 1 : 0;
      if ($rose(s_axi_bvalid) && s_axi_bresp == 2'h0) begin
        case (wa)
          `OFS_LOOP_LATENCY: sh_loop <= wd;
          `OFS_PAD_IMPEDANCE: sh_pad <= wd;
          `OFS_CAL_GATE: gate_open <= wd[0];
          `OFS_REFRESH_CTRL: sh_ref <= wd[1:0];
          default: ;
        endcase
      end
    end
  end

  chk_loop_reset_bit: assert property (
    quiet == 2'h3 |-> loop_reset == sh_loop[5]) else $error("loop reset level wrong");
  chk_power_down_and: assert property (
    quiet == 2'h3 |-> loop_power_down == (sh_loop[4] & sh_ref[0] & sh_ref[1]))
    else $error("power down wrong");
  chk_cal_enable_bit: assert property (
    quiet == 2'h3 |-> impedance_calibration_enable == sh_pad[13]) else $error("enable wrong");
  chk_pad_code_drive: assert property (
    quiet == 2'h3 |-> {p_channel_code, n_channel_code} == sh_pad[9:0])
    else $error("pad codes wrong");
  chk_cal_start_edge: assert property (
    $rose(s_axi_bvalid) && s_axi_bresp == 2'h0 && start |-> ##[1:3] calibration_busy)
    else $error("calibration did not start");
  chk_busy_has_cause: assert property (
    $rose(calibration_busy) |-> sh_pad[15] && sh_pad[13]) else $error("spurious start");
  chk_cal_disabled_idle: assert property (
    quiet == 2'h3 && !sh_pad[13] |-> !calibration_busy) else $error("busy while disabled");
  chk_busy_full_length: assert property (
    $fell(calibration_busy) && sh_pad[13] |-> bcnt == CAL_CYCLES_P)
    else $error("calibration length wrong");
  chk_result_gate_closed: assert property (
    s_axi_rvalid && ra == `OFS_CAL_RESULT && !gate_open |-> s_axi_rdata == 32'h0
    && s_axi_rresp == 2'h2) else $error("gated result leaked");
  chk_result_upper_zero: assert property (
    s_axi_rvalid && ra == `OFS_CAL_RESULT |-> s_axi_rdata[31:10] == 22'h0)
    else $error("result upper bits set");
endmodule

bind ddr_phy_dll_impedance_ctrl ddr_phy_checker #(.ADDR_W(ADDR_W),
  .CAL_CYCLES_P(CAL_CYCLES_P)) ddr_phy_checker_inst (.*);

// file: tb/test_ddr_phy_dll_impedance_ctrl.sv
// Self-checking bench for the PHY loop, read latency and pad impedance bank
`include "phy_ctrl_regs.svh"

`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end

module test_ddr_phy_dll_impedance_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 40;
  localparam int CAS = 3;
  logic ref_clk, rst_n, read_issue, read_capture, data_valid, calibration_busy;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic loop_reset, loop_power_down, impedance_calibration_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, board_delay;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, w;
  logic [4:0] measured_p_code, measured_n_code, p_channel_code, n_channel_code;
  logic [31:0] m[logic [7:0]];
  int n_mismatch, checks_done;

  ddr_phy_dll_impedance_ctrl #(.CAL_CYCLES_P(CAL)) ddr_phy_dll_impedance_ctrl_inst (.*);
  ddr_mem_model #(.CAS_LAT(CAS)) ddr_mem_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .board_delay(board_delay), .read_issue(read_issue), .data_valid(data_valid));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounded wait; a hang counts as a mismatch and ends the run
  task automatic wait_v(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s !== v && n < 64);
    if (s !== v) begin
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 64 && !(ad && wd); n++) begin
      @(posedge ref_clk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    wait_v(s_axi_bvalid, 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_v(s_axi_arready, 1'b1);
    s_axi_arvalid <= 1'b0;
    wait_v(s_axi_rvalid, 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, d)
    `CHK(s_axi_rresp, r)
    @(posedge ref_clk);
  endtask

  // Model write: result place is read-only, gated by the enable word
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    r = m.exists(a) ? 2'h0 : 2'h3;
    if (a == `OFS_CAL_RESULT) r = m[`OFS_CAL_GATE][0] ? 2'h0 : 2'h2;
    else if (r == 2'h0) m[a] = (a == `OFS_LOOP_LATENCY) ? d | 32'h8 : d;
    wr(a, d, r);
  endtask

  task automatic get(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    d = m.exists(a) ? m[a] : 32'h0;
    r = m.exists(a) ? 2'h0 : 2'h3;
    if (a == `OFS_CAL_RESULT && m[`OFS_CAL_GATE][0] == 1'b0) r = 2'h2;
    if (r != 2'h0) d = 32'h0;
    rd(a, d, r);
  endtask

  task automatic no_busy;
    repeat (6) @(posedge ref_clk);
    `CHK(calibration_busy, 1'b0)
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, read_issue} = 49'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb, board_delay} = 13'h07A;
    {measured_p_code, measured_n_code} = 10'h000;
    rst_n = 1'b0;
    m[`OFS_LOOP_LATENCY] = 'x;
    m[`OFS_PAD_IMPEDANCE] = 32'h1F;
    m[`OFS_CAL_RESULT] = 32'h0;
    m[`OFS_CAL_GATE] = 32'h0;
    m[`OFS_REFRESH_CTRL] = 32'h0;
    void'($urandom(32'h8B806E3B));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    // Reset state of outputs and registers
    `CHK({loop_reset, loop_power_down, impedance_calibration_enable}, 3'h4)
    `CHK({p_channel_code, n_channel_code}, 10'h01F)
    get(`OFS_PAD_IMPEDANCE);
    get(`OFS_CAL_RESULT);
    get(`OFS_CAL_GATE);
    $display("test reset done");
    // Every reset, power-down and refresh combination
    for (int i = 0; i < 16; i++) begin
      put(`OFS_LOOP_LATENCY, 32'h50006405 | (i[1:0] << 4));
      put(`OFS_REFRESH_CTRL, {30'h0, i[3:2]});
      repeat (3) @(posedge ref_clk);
      `CHK(loop_reset, i[1])
      `CHK(loop_power_down, i[0] & i[2] & i[3])
      get(`OFS_LOOP_LATENCY);
    end
    $display("test loop control done");
    // Capture must meet the returning data for each legal board delay
    for (int b = 2; b <= 4; b++) begin
      board_delay <= b[2:0];
      put(`OFS_LOOP_LATENCY, 32'h50006400 | (CAS + b - 1));
      read_issue <= 1'b1;
      repeat (2) @(posedge ref_clk);
      read_issue <= 1'b0;
      repeat (10) begin
        @(posedge ref_clk);
        `CHK(read_capture, data_valid)
      end
    end
    $display("test read latency done");
    repeat (4) begin
      w = $urandom & 32'h3FF;
      put(`OFS_PAD_IMPEDANCE, w);
      repeat (3) @(posedge ref_clk);
      `CHK({p_channel_code, n_channel_code}, w[9:0])
      get(`OFS_PAD_IMPEDANCE);
    end
    $display("test pad codes done");
    // Calibration: enable first, then a fresh rising start bit
    measured_p_code <= 5'($urandom);
    measured_n_code <= 5'($urandom);
    put(`OFS_PAD_IMPEDANCE, 32'hA000);
    no_busy();
    put(`OFS_PAD_IMPEDANCE, 32'h2000);
    put(`OFS_PAD_IMPEDANCE, 32'hA000);
    wait_v(calibration_busy, 1'b1);
    wait_v(calibration_busy, 1'b0);
    m[`OFS_CAL_RESULT] = {22'h0, measured_p_code, measured_n_code};
    get(`OFS_CAL_RESULT);
    put(`OFS_CAL_GATE, 32'h1);
    put(`OFS_CAL_RESULT, ~m[`OFS_CAL_RESULT]);
    get(`OFS_CAL_RESULT);
    put(`OFS_PAD_IMPEDANCE, 32'hA000 | m[`OFS_CAL_RESULT]);
    no_busy();
    `CHK({p_channel_code, n_channel_code}, m[`OFS_CAL_RESULT][9:0])
    // Clearing the enable mid-run aborts the calibration
    put(`OFS_PAD_IMPEDANCE, 32'h2000);
    put(`OFS_PAD_IMPEDANCE, 32'hA000);
    wait_v(calibration_busy, 1'b1);
    put(`OFS_PAD_IMPEDANCE, 32'h8000);
    repeat (2) @(posedge ref_clk);
    `CHK(calibration_busy, 1'b0)
    put(`OFS_CAL_GATE, 32'h0);
    get(`OFS_CAL_RESULT);
    $display("test calibration done");
    put(8'h00, 32'h1234);
    get(8'h10);
    $display("test unmapped done");
    end_sim();
  end
endmodule
